/* File: design/ipme_pkg.sv */
// Constants and types for the eight-line priority, mask and finish block.
// Assumes a single core clock; initialization words are applied elsewhere.
package ipme_pkg;

   // ==========================================================
   // Port map, selected by the port select line
   localparam logic [7:0] OFFSET_PRIORITY_COMMAND = 8'h20;
   localparam logic [7:0] OFFSET_LINE_MASK = 8'h21;
   localparam logic PORT_COMMAND = OFFSET_PRIORITY_COMMAND[0];
   localparam logic PORT_MASK = OFFSET_LINE_MASK[0];

   // ==========================================================
   // Priority command word fields
   localparam int PC_ROTATE_BIT = 7;
   localparam int PC_TARGETED_BIT = 6;
   localparam int PC_FINISH_BIT = 5;
   localparam int PC_KIND_HI = 4;
   localparam int PC_KIND_LO = 3;
   localparam int PC_LINE_HI = 2;
   localparam logic [1:0] PC_KIND_PRIORITY = 2'h0;
   localparam int VB_BASE_LO = 3;

   // Codes of {rotate, targeted, finish}
   localparam logic [2:0] CMD_CLEAR_AUTO_ROT = 3'h0;
   localparam logic [2:0] CMD_FINISH = 3'h1;
   localparam logic [2:0] CMD_NOP = 3'h2;
   localparam logic [2:0] CMD_TARGET_FINISH = 3'h3;
   localparam logic [2:0] CMD_SET_AUTO_ROT = 3'h4;
   localparam logic [2:0] CMD_ROT_FINISH = 3'h5;
   localparam logic [2:0] CMD_SET_PRIORITY = 3'h6;
   localparam logic [2:0] CMD_ROT_TARGET_FINISH = 3'h7;

   // ==========================================================
   // Reset values
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [7:0] PENDING_RESET = 8'h00;
   localparam logic [7:0] IN_SERVICE_RESET = 8'h00;
   localparam logic [2:0] LOWEST_RESET = 3'h7;
   localparam logic [2:0] SPURIOUS_LINE = 3'h7;
   localparam logic [7:0] DATA_RESET = 8'h00;
   // Idle pin levels: requests low, strobes high
   localparam int SYNC_WIDTH = 21;
   localparam logic [20:0] SYNC_IDLE = 21'h0_0017;

   // ==========================================================
   // Acknowledge sequence
   typedef enum logic [3:0] {
      ACK_IDLE = 4'b0001,
      ACK_FIRST = 4'b0010,
      ACK_GAP = 4'b0100,
      ACK_SECOND = 4'b1000
   } ipme_ack_state_t;

endpackage

/* File: design/ipme_sync.sv */
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes the bits are independent levels; multi-bit words are only used
// while their qualifying strobe is held stable.
`timescale 1ns/100ps
module ipme_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] IDLE = '0
) (
   input wire logic core_clk,
   input wire logic rst_sync_b,
   input wire logic [WIDTH-1:0] pin_levels,
   output logic [WIDTH-1:0] synced_levels
);

   logic [WIDTH-1:0] meta_reg;

   // ==========================================================
   // First stage feeds only the second
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         meta_reg <= IDLE;
         synced_levels <= IDLE;
      end
      else
      begin
         meta_reg <= pin_levels;
         synced_levels <= meta_reg;
      end
   end

endmodule // ipme_sync

/* File: design/ipme_core.sv */
// Priority resolution, line masking and finish handling for eight lines.
// Assumes vector base and auto finish flag come from init logic, held stable.
// Notes on behaviour
// - Reset gives fully nested, line zero highest
// - Acknowledge returns vector of highest pending line
// - Idle grant sets in-service, clears pending
// - Strictly higher request nests over service
// - Equal or lower request waits pending
// - Pending clears only when serviced
// - Finish command clears the matching service
// - Plain finish clears highest in-service bit
// - Low three bits select targeted line
// - Auto finish acts as plain finish
// - Commands accepted in any order
// - Mask bit n blocks line n
// - Masked in-service line still blocks lower
// - Command bits: rotate, targeted, finish, line
// - Rotating plain finish makes cleared line lowest
// - Rotate-on-auto set by 80H, cleared by 00H
// - Set priority rotates without clearing service
// - Rotating targeted finish rotates and clears
// - Rotation bounds wait to seven others
// - Vector is five-bit base plus line
// - Auto finish at second acknowledge end
`timescale 1ns/100ps
module ipme_core (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic cs_b,
   input wire logic rd_b,
   input wire logic wr_b,
   input wire logic port_select_line,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   input wire logic [7:0] request_lines,
   input wire logic inta_b,
   output logic int_req,
   input wire logic [7:0] vector_base_word,
   input wire logic auto_finish_flag,
   input wire logic reg_read_sel,
   output logic [7:0] pending_bits,
   output logic [7:0] in_service_bits,
   output logic [7:0] line_mask_bits,
   output logic [2:0] lowest_line
);

   // ==========================================================
   // Reset release and pin synchronisation
   logic rst_meta_b;
   logic rst_sync_b;
   logic [ipme_pkg::SYNC_WIDTH-1:0] sync_levels;
   logic [7:0] s_ir, s_data;
   logic s_inta_b, s_a0, s_cs_b, s_rd_b, s_wr_b;
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rst_meta_b <= 1'b0;
         rst_sync_b <= 1'b0;
      end
      else
      begin
         rst_meta_b <= 1'b1;
         rst_sync_b <= rst_meta_b;
      end
   end
   ipme_sync #(
      .WIDTH(ipme_pkg::SYNC_WIDTH),
      .IDLE(ipme_pkg::SYNC_IDLE)
   ) u_sync (
      .core_clk(core_clk),
      .rst_sync_b(rst_sync_b),
      .pin_levels({request_lines, data_in, inta_b, port_select_line, cs_b, rd_b, wr_b}),
      .synced_levels(sync_levels)
   );
   assign {s_ir, s_data, s_inta_b, s_a0, s_cs_b, s_rd_b, s_wr_b} = sync_levels;

   // ==========================================================
   // Priority helpers
   // Returns {found, line}; search starts just after the lowest line
   function automatic logic [3:0] pick_top(input logic [7:0] bits, input logic [2:0] lowest);
      logic [2:0] idx;
      logic [3:0] res;
      res = 4'h0;
      for (int k = 7; k >= 0; k--)
      begin
         idx = 3'(lowest + 3'(k) + 3'h1);
         if (bits[idx])
            res = {1'b1, idx};
      end
      return res;
   endfunction
   // Zero is the highest rank
   function automatic logic [2:0] rank(input logic [2:0] line, input logic [2:0] lowest);
      return 3'(line - lowest - 3'h1);
   endfunction

   // ==========================================================
   // Write strobe: data caught while the strobe is low, applied at its end
   logic wr_active, wr_active_reg, wr_a0_reg, wr_commit, mask_write, prio_write;
   logic [7:0] wr_data_reg;
   logic [2:0] cmd, cmd_line;
   assign wr_active = !s_wr_b && !s_cs_b && s_rd_b;
   assign wr_commit = wr_active_reg && !wr_active;
   assign mask_write = wr_commit && (wr_a0_reg == ipme_pkg::PORT_MASK);
   assign prio_write = wr_commit && (wr_a0_reg == ipme_pkg::PORT_COMMAND)
      && (wr_data_reg[ipme_pkg::PC_KIND_HI:ipme_pkg::PC_KIND_LO] == ipme_pkg::PC_KIND_PRIORITY);
   assign cmd = {wr_data_reg[ipme_pkg::PC_ROTATE_BIT], wr_data_reg[ipme_pkg::PC_TARGETED_BIT],
      wr_data_reg[ipme_pkg::PC_FINISH_BIT]};
   assign cmd_line = wr_data_reg[ipme_pkg::PC_LINE_HI:0];
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         wr_active_reg <= 1'b0;
         wr_data_reg <= ipme_pkg::DATA_RESET;
         wr_a0_reg <= ipme_pkg::PORT_COMMAND;
      end
      else
      begin
         wr_active_reg <= wr_active;
         if (wr_active)
         begin
            wr_data_reg <= s_data;
            wr_a0_reg <= s_a0;
         end
      end
   end

   // ==========================================================
   // Mask and rotation state; each write stands alone, no ordering
   logic rot_auto_reg;
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         line_mask_bits <= ipme_pkg::MASK_RESET;
      else if (mask_write)
         line_mask_bits <= wr_data_reg;
   end
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         rot_auto_reg <= 1'b0;
      else if (prio_write && cmd == ipme_pkg::CMD_SET_AUTO_ROT)
         rot_auto_reg <= 1'b1;
      else if (prio_write && cmd == ipme_pkg::CMD_CLEAR_AUTO_ROT)
         rot_auto_reg <= 1'b0;
   end

   // ==========================================================
   // Resolution
   logic [3:0] req_top, isr_top;
   logic grant_ok;
   // In-service bits are not masked, so a masked line keeps blocking
   assign req_top = pick_top(pending_bits & ~line_mask_bits, lowest_line);
   assign isr_top = pick_top(in_service_bits, lowest_line);
   assign grant_ok = req_top[3] && (!isr_top[3]
      || rank(req_top[2:0], lowest_line) < rank(isr_top[2:0], lowest_line));
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         int_req <= 1'b0;
      else
         int_req <= grant_ok;
   end

   // ==========================================================
   // Acknowledge sequence: first pulse grants, second carries the vector
   ipme_pkg::ipme_ack_state_t ack_state_reg;
   logic ack_take, ack_done, ack_drive, granted_valid_reg;
   logic [2:0] granted_line_reg;
   assign ack_take = (ack_state_reg == ipme_pkg::ACK_IDLE) && !s_inta_b;
   assign ack_done = (ack_state_reg == ipme_pkg::ACK_SECOND) && s_inta_b;
   assign ack_drive = (ack_state_reg == ipme_pkg::ACK_SECOND) && !s_inta_b;
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         ack_state_reg <= ipme_pkg::ACK_IDLE;
      else
      begin
         case (ack_state_reg)
            ipme_pkg::ACK_IDLE: if (!s_inta_b) ack_state_reg <= ipme_pkg::ACK_FIRST;
            ipme_pkg::ACK_FIRST: if (s_inta_b) ack_state_reg <= ipme_pkg::ACK_GAP;
            ipme_pkg::ACK_GAP: if (!s_inta_b) ack_state_reg <= ipme_pkg::ACK_SECOND;
            ipme_pkg::ACK_SECOND: if (s_inta_b) ack_state_reg <= ipme_pkg::ACK_IDLE;
            default: ack_state_reg <= ipme_pkg::ACK_IDLE;
         endcase
      end
   end
   // No grantable request at the first pulse answers with the last line
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         granted_line_reg <= ipme_pkg::SPURIOUS_LINE;
         granted_valid_reg <= 1'b0;
      end
      else if (ack_take)
      begin
         granted_line_reg <= grant_ok ? req_top[2:0] : ipme_pkg::SPURIOUS_LINE;
         granted_valid_reg <= grant_ok;
      end
   end

   // ==========================================================
   // Pending: edge-caught; a new edge wins over a same-cycle grant
   logic [7:0] ir_prev_reg, grant_mask;
   assign grant_mask = (ack_take && grant_ok) ? (8'h01 << req_top[2:0]) : 8'h00;
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         ir_prev_reg <= 8'h00;
         pending_bits <= ipme_pkg::PENDING_RESET;
      end
      else
      begin
         ir_prev_reg <= s_ir;
         pending_bits <= (pending_bits & ~grant_mask) | (s_ir & ~ir_prev_reg);
      end
   end

   // ==========================================================
   // In-service and rotation; a grant wins over any same-cycle clear
   logic [7:0] finish_mask;
   logic auto_finish;
   assign auto_finish = ack_done && auto_finish_flag && granted_valid_reg;
   always_comb
   begin
      finish_mask = 8'h00;
      if (prio_write && (cmd == ipme_pkg::CMD_FINISH || cmd == ipme_pkg::CMD_ROT_FINISH)
         && isr_top[3])
         finish_mask = 8'h01 << isr_top[2:0];
      if (prio_write && (cmd == ipme_pkg::CMD_TARGET_FINISH
         || cmd == ipme_pkg::CMD_ROT_TARGET_FINISH))
         finish_mask = 8'h01 << cmd_line;
      if (auto_finish)
         finish_mask = finish_mask | (8'h01 << granted_line_reg);
   end
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         in_service_bits <= ipme_pkg::IN_SERVICE_RESET;
      else
         in_service_bits <= (in_service_bits & ~finish_mask) | grant_mask;
   end
   // Serviced line drops to lowest, so it waits on seven others at most
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
         lowest_line <= ipme_pkg::LOWEST_RESET;
      else if (prio_write && cmd == ipme_pkg::CMD_ROT_FINISH && isr_top[3])
         lowest_line <= isr_top[2:0];
      else if (prio_write && (cmd == ipme_pkg::CMD_SET_PRIORITY
         || cmd == ipme_pkg::CMD_ROT_TARGET_FINISH))
         lowest_line <= cmd_line;
      else if (auto_finish && rot_auto_reg)
         lowest_line <= granted_line_reg;
   end

   // ==========================================================
   // Data bus: vector during second pulse, else register read
   logic rd_active;
   assign rd_active = !s_rd_b && !s_cs_b && s_wr_b;
   always_ff @(posedge core_clk or negedge rst_sync_b)
   begin
      if (!rst_sync_b)
      begin
         data_out <= ipme_pkg::DATA_RESET;
         data_oe <= 1'b0;
      end
      else
      begin
         data_oe <= ack_drive || rd_active;
         if (ack_drive)
            data_out <= {vector_base_word[7:ipme_pkg::VB_BASE_LO], granted_line_reg};
         else if (rd_active && s_a0 == ipme_pkg::PORT_MASK)
            data_out <= line_mask_bits;
         else if (rd_active)
            data_out <= reg_read_sel ? in_service_bits : pending_bits;
      end
   end

   // ==========================================================
   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_sync_b);
   sequence second_pulse_held;
      (ack_state_reg == ipme_pkg::ACK_GAP && !s_inta_b) ##1 !s_inta_b;
   endsequence
   sequence plain_rot_finish;
      prio_write && cmd == ipme_pkg::CMD_ROT_FINISH && isr_top[3] && !ack_take;
   endsequence

   AST_MASK_WRITE:
      assert property (mask_write |=> line_mask_bits == $past(wr_data_reg))
         else $error("Mask write not applied next cycle");
   AST_GRANT_SETS:
      assert property ((ack_take && grant_ok) |=> in_service_bits[granted_line_reg]
         && granted_valid_reg)
         else $error("Grant did not set in-service bit");
   AST_LOWER_WAITS:
      assert property ((isr_top[3] && req_top[3] && rank(req_top[2:0], lowest_line)
         >= rank(isr_top[2:0], lowest_line)) |=> !int_req)
         else $error("Lower or equal request raised interrupt");
   AST_PENDING_HELD:
      assert property (!ack_take |=> (pending_bits & $past(pending_bits)) == $past(pending_bits))
         else $error("Pending bit lost without service");
   AST_MASK_BLOCKS:
      assert property (((pending_bits & ~line_mask_bits) == 8'h00) |=> !int_req)
         else $error("Interrupt raised with all requests masked");
   AST_ROT_FINISH:
      assert property (plain_rot_finish |=> lowest_line == $past(isr_top[2:0])
         && !in_service_bits[$past(isr_top[2:0])])
         else $error("Rotating finish mishandled");
   AST_SET_PRIORITY:
      assert property ((prio_write && cmd == ipme_pkg::CMD_SET_PRIORITY && !ack_take)
         |=> lowest_line == $past(cmd_line) && in_service_bits == $past(in_service_bits))
         else $error("Set priority wrong");
   AST_TARGET_FINISH:
      assert property ((prio_write && cmd == ipme_pkg::CMD_TARGET_FINISH && !ack_take)
         |=> !in_service_bits[wr_data_reg[2:0]])
         else $error("Targeted finish did not clear line");
   AST_VECTOR:
      assert property (second_pulse_held |=> data_oe
         && data_out == {vector_base_word[7:3], granted_line_reg})
         else $error("Vector not driven on second pulse");
   AST_AUTO_FINISH:
      assert property (auto_finish |=> !in_service_bits[granted_line_reg])
         else $error("Auto finish did not clear in-service");

endmodule // ipme_core

/* File: test/ipme_host.sv */
// Host processor model: byte writes, byte reads and two-pulse acknowledges.
// Assumes the bench calls its tasks one at a time; strobes move after clock edges.
`timescale 1ns/100ps
module ipme_host (
   input wire logic core_clk,
   input wire logic [7:0] data_out,
   input wire logic data_oe,
   output logic cs_b,
   output logic rd_b,
   output logic wr_b,
   output logic port_select_line,
   output logic [7:0] data_in,
   output logic inta_b
);
   initial
   begin
      cs_b = 1'b1;
      rd_b = 1'b1;
      wr_b = 1'b1;
      port_select_line = 1'b0;
      data_in = 8'h00;
      inta_b = 1'b1;
   end

   // ==========================================================
   // Mask on the high port, every other command on the low port
   task automatic wr(input logic a0, input logic [7:0] d);
      @(posedge core_clk);
      cs_b <= 1'b0;
      wr_b <= 1'b0;
      port_select_line <= a0;
      data_in <= d;
      repeat (3) @(posedge core_clk);
      cs_b <= 1'b1;
      wr_b <= 1'b1;
      // Data outlives the strobe by the sync lag, then goes stale
      repeat (3) @(posedge core_clk);
      data_in <= ~d;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic rd(input logic a0, output logic [7:0] d);
      @(posedge core_clk);
      cs_b <= 1'b0;
      rd_b <= 1'b0;
      port_select_line <= a0;
      repeat (5) @(posedge core_clk);
      d = data_out;
      cs_b <= 1'b1;
      rd_b <= 1'b1;
      repeat (5) @(posedge core_clk);
   endtask

   // ==========================================================
   // Two pulses; vector taken late in the second one
   task automatic ack(output logic [8:0] v);
      @(posedge core_clk);
      inta_b <= 1'b0;
      repeat (4) @(posedge core_clk);
      inta_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      inta_b <= 1'b0;
      repeat (5) @(posedge core_clk);
      v = {data_oe, data_out};
      inta_b <= 1'b1;
      repeat (6) @(posedge core_clk);
   endtask
endmodule // ipme_host

/* File: test/irq_priority_mask_eoi_tb.sv */
// Self-checking bench for the priority, mask and finish block.
// Assumes the host model drives the bus; requests are short rising pulses.
`timescale 1ns/100ps
module irq_priority_mask_eoi_tb;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic cs_b, rd_b, wr_b, port_select_line, inta_b, data_oe, int_req;
   logic [7:0] data_in, data_out, pending_bits, in_service_bits, line_mask_bits;
   logic [7:0] request_lines = 8'h00;
   logic [7:0] vector_base_word = 8'h00;
   logic auto_finish_flag = 1'b0;
   logic reg_read_sel = 1'b0;
   logic [2:0] lowest_line;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   logic [7:0] vb, m, d, pend;
   logic [8:0] a;
   logic [3:0] ln;
   logic [2:0] exp_low;

   always #12.5 core_clk = ~core_clk;

   ipme_core u_ipme_core (.core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b),
      .wr_b(wr_b), .port_select_line(port_select_line), .data_in(data_in),
      .data_out(data_out), .data_oe(data_oe), .request_lines(request_lines),
      .inta_b(inta_b), .int_req(int_req), .vector_base_word(vector_base_word),
      .auto_finish_flag(auto_finish_flag), .reg_read_sel(reg_read_sel),
      .pending_bits(pending_bits), .in_service_bits(in_service_bits),
      .line_mask_bits(line_mask_bits), .lowest_line(lowest_line));

   ipme_host u_ipme_host (.core_clk(core_clk), .data_out(data_out), .data_oe(data_oe),
      .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b), .port_select_line(port_select_line),
      .data_in(data_in), .inta_b(inta_b));

   // ==========================================================
   // Helpers
   // Highest-priority set bit, the line after low first; 8 when none
   function automatic logic [3:0] pick(input logic [7:0] b, input logic [2:0] low);
      logic [2:0] i;
      pick = 4'h8;
      for (int k = 8; k >= 1; k--)
      begin
         i = low + 3'(k);
         if (b[i])
            pick = {1'b0, i};
      end
   endfunction

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      if (n_errors == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic req(input logic [7:0] v);
      @(posedge core_clk);
      request_lines <= v;
      repeat (2) @(posedge core_clk);
      request_lines <= 8'h00;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic ack_chk(input logic [2:0] line);
      u_ipme_host.ack(a);
      check("vector", a[7:0], {vb[7:3], line});
      check("vector_oe", {7'h00, a[8]}, 8'h01);
   endtask

   task automatic irq_chk(input logic exp);
      check("int_req", {7'h00, int_req}, {7'h00, exp});
   endtask

   // Hang guard: the sequence needs well under a thousand cycles
   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         n_errors++;
         final_report();
      end
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      void'($urandom(8991));
      vb = 8'($urandom);
      vector_base_word <= vb;
      repeat (12) @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge core_clk);
      check("lowest", {5'h00, lowest_line}, 8'h07);
      check("isr", in_service_bits, 8'h00);
      // Every line masked until its handler exists
      u_ipme_host.wr(1'b1, 8'hFF);
      check("mask_all", line_mask_bits, 8'hFF);
      m = 8'($urandom);
      u_ipme_host.wr(1'b1, m);
      check("mask", line_mask_bits, m);
      u_ipme_host.rd(1'b1, d);
      check("mask_rd", d, m);
      u_ipme_host.wr(1'b1, 8'h00);
      // Nesting under the fixed order
      req(8'h20);
      irq_chk(1'b1);
      ack_chk(3'h5);
      check("isr", in_service_bits, 8'h20);
      check("pend", pending_bits, 8'h00);
      req(8'h04);
      irq_chk(1'b1);
      ack_chk(3'h2);
      check("isr", in_service_bits, 8'h24);
      req(8'h40);
      irq_chk(1'b0);
      u_ipme_host.rd(1'b0, d);
      check("pend_rd", d, 8'h40);
      reg_read_sel <= 1'b1;
      u_ipme_host.rd(1'b0, d);
      check("isr_rd", d, 8'h24);
      u_ipme_host.wr(1'b0, 8'h20);
      check("isr", in_service_bits, 8'h20);
      u_ipme_host.wr(1'b1, 8'h20);
      irq_chk(1'b0);
      u_ipme_host.wr(1'b0, 8'h65);
      check("isr", in_service_bits, 8'h00);
      irq_chk(1'b1);
      u_ipme_host.wr(1'b1, 8'h40);
      irq_chk(1'b0);
      u_ipme_host.wr(1'b1, 8'h00);
      irq_chk(1'b1);
      ack_chk(3'h6);
      u_ipme_host.wr(1'b0, 8'hC4);
      check("lowest", {5'h00, lowest_line}, 8'h04);
      check("isr", in_service_bits, 8'h40);
      // Bits 4:3 not zero: not a priority command
      u_ipme_host.wr(1'b0, 8'hC9);
      check("lowest", {5'h00, lowest_line}, 8'h04);
      u_ipme_host.wr(1'b0, 8'hA0);
      check("isr", in_service_bits, 8'h00);
      check("lowest", {5'h00, lowest_line}, 8'h06);
      // Automatic finish, with and without rotation
      auto_finish_flag <= 1'b1;
      u_ipme_host.wr(1'b0, 8'h80);
      req(8'h08);
      ack_chk(3'h3);
      check("isr", in_service_bits, 8'h00);
      check("lowest", {5'h00, lowest_line}, 8'h03);
      u_ipme_host.wr(1'b0, 8'h00);
      req(8'h02);
      ack_chk(3'h1);
      check("isr", in_service_bits, 8'h00);
      check("lowest", {5'h00, lowest_line}, 8'h03);
      auto_finish_flag <= 1'b0;
      // Random bursts under rotating priority
      pend = 8'h00;
      exp_low = 3'h3;
      for (int n = 0; n < 10; n++)
      begin
         m = 8'($urandom_range(1, 255));
         req(m);
         pend = pend | m;
         ln = pick(pend, exp_low);
         ack_chk(ln[2:0]);
         pend[ln[2:0]] = 1'b0;
         check("pend", pending_bits, pend);
         check("isr", in_service_bits, 8'h01 << ln[2:0]);
         u_ipme_host.wr(1'b0, 8'hE0 | {5'h00, ln[2:0]});
         check("isr", in_service_bits, 8'h00);
         check("lowest", {5'h00, lowest_line}, {5'h00, ln[2:0]});
         exp_low = ln[2:0];
      end
      final_report();
   end
endmodule // irq_priority_mask_eoi_tb
